/* src/wdg_pkg.sv */
// Function
// RL1: Software restarts counter before changing prescaler.
// RL2: Unused reset-cause bits 7..4 read zero.
// RL3: Watchdog reset sets its cause flag.
// RL4: Brown-out reset sets its cause flag.
// RL5: External reset sets its cause flag.
// RL6: Power-on flag cleared only by software zero.
// RL7: Software reads then clears cause flags early.
// RL8: Control register at 0x60 with fixed fields.
// RL9: Time-out flag set, cleared by vector or one.
// RL10: Interrupt needs global enable, enable and flag.
// RL11: Reset and interrupt enables select four modes.
// RL12: Programmed always-on fuse forces system reset mode.
// RL13: Vector in combined mode clears enable and flag.
// RL14: Second unserviced time-out in combined mode resets.
// RL15: Software re-arms interrupt enable after each interrupt.
// RL16: Change enable guards changes, self-clears after four.
// RL17: Reset enable stays set while watchdog flag set.
// RL18: Codes zero to nine give 2048 to 1048576 cycles.
// RL19: Unlock write, then configuration write within four cycles.
// RL20: Counter advances on the dedicated oscillator.
// RL21: Reset time-out gives one-cycle reset pulse.
// RL22: Restart instruction clears the counter.
// RL23: Oscillator and events are synchronised without loss.
// RL24: Reserved codes act as the longest period.
package wdg_pkg;

  // ==========================================================
  // Register map and layout.
  localparam logic [11:0] ADDR_CTRL  = 12'h060;
  localparam logic [11:0] ADDR_CAUSE = 12'h064;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  CAUSE_RST  = 8'h01;

  // ==========================================================
  // Timing and counter sizes.
  localparam int unsigned OSC_FREQ_KHZ = 128;
  localparam logic [2:0]  CE_CYCLES    = 3'h4;
  localparam logic [3:0]  PRE_MAX      = 4'h9;
  localparam int unsigned CNT_W        = 21;

  // ==========================================================
  // Types.
  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_IRQ  = 2'b01,
    MODE_RST  = 2'b10,
    MODE_BOTH = 2'b11
  } wdg_mode_t;

  typedef struct packed {
    logic       timeout_flag;
    logic       timeout_interrupt_enable;
    logic       prescaler_code_hi;
    logic       change_enable;
    logic       system_reset_enable;
    logic [2:0] prescaler_code_lo;
  } wdg_ctrl_t;

  typedef struct packed {
    logic [3:0] unused;
    logic       watchdog_reset_cause_flag;
    logic       brownout_cause_flag;
    logic       external_pin_cause_flag;
    logic       power_on_cause_flag;
  } wdg_cause_t;

endpackage

/* src/wdg_top.sv */
// The APB slave port was left to the implementer.
`timescale 1ns/1ps

// ==========================================================
// Two-flop synchroniser for levels from other domains.
module wdg_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,    // Core clock.
  input  wire logic         presetn, // Asynchronous reset, low.
  input  wire logic [W-1:0] din,     // Asynchronous level in.
  output logic      [W-1:0] dout     // Synchronised level.
);
  logic [W-1:0] meta_q;

  // Second flop only reads the first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ==========================================================
// Watchdog with control/status and reset-cause registers.
module wdg_top import wdg_pkg::*; #(
  parameter int unsigned TIMEOUT_BASE = 2048
) (
  input  wire logic        pclk,              // Core clock, 250 MHz.
  input  wire logic        presetn,           // Power-on reset, low.
  input  wire logic        psel,              // APB select.
  input  wire logic        penable,           // APB enable.
  input  wire logic        pwrite,            // APB write.
  input  wire logic [11:0] paddr,             // APB byte address.
  input  wire logic [31:0] pwdata,            // APB write data.
  output logic      [31:0] prdata,            // APB read data.
  output logic             pready,            // APB ready.
  output logic             pslverr,           // APB error.
  input  wire logic        osc_clk_in,        // Watchdog oscillator.
  input  wire logic        always_on_fuse,    // Fuse, 0 programmed.
  input  wire logic        global_int_enable, // Core status I bit.
  input  wire logic        vector_exec,       // Vector taken, pulse.
  input  wire logic        restart_exec,      // Restart instr, pulse.
  input  wire logic        brownout_reset,    // Brown-out level.
  input  wire logic        external_reset,    // External pin level.
  output logic             irq_req,           // Interrupt request.
  output logic             sys_reset_pulse    // System reset pulse.
);
  // Every check in this block samples on the core clock and sleeps during reset.
  default clocking cb_core @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Synchronisers and edge detection.
  logic [3:0] sync_w;
  logic       osc_prev_q;
  logic       bor_prev_q;
  logic       ext_prev_q;
  logic       osc_rise;
  logic       bor_rise;
  logic       ext_rise;
  logic       fuse_prog;

  wdg_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({osc_clk_in, always_on_fuse, brownout_reset, external_reset}),
    .dout    (sync_w)
  );

  // Previous synchronised levels for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_q <= 1'b0;
      bor_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= sync_w[3];
      bor_prev_q <= sync_w[1];
      ext_prev_q <= sync_w[0];
    end
  end

  assign osc_rise  = sync_w[3] & ~osc_prev_q; // RL20 RL23
  assign bor_rise  = sync_w[1] & ~bor_prev_q; // RL23
  assign ext_rise  = sync_w[0] & ~ext_prev_q; // RL23
  assign fuse_prog = ~sync_w[2];

  // ==========================================================
  // APB decode.
  logic       apb_wr;
  logic       wr_ctrl;
  logic       wr_cause;
  logic       rd_setup;
  wdg_ctrl_t  w;
  wdg_ctrl_t  ctrl_view;
  wdg_cause_t cause_q;

  assign pready   = 1'b1;
  assign apb_wr   = psel & penable & pwrite;
  assign wr_ctrl  = apb_wr & (paddr == ADDR_CTRL);
  assign wr_cause = apb_wr & (paddr == ADDR_CAUSE);
  assign rd_setup = psel & ~penable & ~pwrite;
  assign w        = wdg_ctrl_t'(pwdata[7:0]);

  // Error answer in the access phase for addresses outside the map.
  always_comb begin
    pslverr = psel & penable;
    if (paddr == ADDR_CTRL || paddr == ADDR_CAUSE) begin
      pslverr = 1'b0;
    end
  end

  // Read data is captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      if (paddr == ADDR_CTRL) begin
        prdata <= {24'h00_0000, ctrl_view}; // RL8
      end else if (paddr == ADDR_CAUSE) begin
        prdata <= {24'h00_0000, 4'h0, cause_q[3:0]}; // RL2
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Change-enable window.
  logic [2:0] ce_cnt_q;
  logic       ce_active;
  logic       cfg_write;

  assign ce_active = ce_cnt_q != 3'h0;
  assign cfg_write = wr_ctrl & ce_active & ~w.change_enable; // RL19

  // Unlock opens a four-cycle window; the config write closes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_cnt_q <= 3'h0;
    end else if (wr_ctrl && w.change_enable && w.system_reset_enable) begin
      ce_cnt_q <= CE_CYCLES; // RL16 RL19
    end else if (cfg_write) begin
      ce_cnt_q <= 3'h0;
    end else if (ce_active) begin
      ce_cnt_q <= ce_cnt_q - 3'h1; // RL16
    end
  end

  // ==========================================================
  // Control fields.
  logic       wde_q;
  logic       timeout_interrupt_enable_q;
  logic       timeout_flag_q;
  logic [3:0] pre_q;
  logic       wde_eff;
  logic       timeout_interrupt_enable_eff;
  logic       irq_set;
  logic       rst_fire;
  logic       tmo;
  wdg_mode_t  mode;

  assign wde_eff  = wde_q | cause_q.watchdog_reset_cause_flag | fuse_prog; // RL17 RL12
  assign timeout_interrupt_enable_eff = timeout_interrupt_enable_q & ~fuse_prog; // RL12

  // Reset enable sets freely; clearing needs the window and no cause flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wde_q <= 1'b0;
    end else if (wr_ctrl && w.system_reset_enable) begin
      wde_q <= 1'b1;
    end else if (cfg_write && !cause_q.watchdog_reset_cause_flag) begin
      wde_q <= 1'b0; // RL16 RL17
    end
  end

  // Prescaler changes only inside the window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 4'h0;
    end else if (cfg_write) begin
      pre_q <= {w.prescaler_code_hi, w.prescaler_code_lo}; // RL16
    end
  end

  // Vector in combined mode drops the interrupt enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_interrupt_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      timeout_interrupt_enable_q <= w.timeout_interrupt_enable;
    end else if (vector_exec && mode == MODE_BOTH) begin
      timeout_interrupt_enable_q <= 1'b0; // RL13
    end
  end

  // Time-out flag: a set in the same cycle beats any clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag_q <= 1'b0;
    end else if (irq_set) begin
      timeout_flag_q <= 1'b1; // RL9
    end else if ((wr_ctrl && w.timeout_flag) || vector_exec) begin
      timeout_flag_q <= 1'b0; // RL9 RL13
    end
  end

  // Read view of the control register, with the effective enables.
  assign ctrl_view = '{timeout_flag_q, timeout_interrupt_enable_eff, pre_q[3], ce_active, wde_eff, pre_q[2:0]}; // RL8

  // ==========================================================
  // Mode, counter and time-out.
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;
  logic [3:0]       pre_eff;

  assign mode    = fuse_prog ? MODE_RST : wdg_mode_t'({wde_eff, timeout_interrupt_enable_q}); // RL11 RL12
  assign pre_eff = (pre_q > PRE_MAX) ? PRE_MAX : pre_q; // RL24
  assign limit   = CNT_W'(TIMEOUT_BASE) << pre_eff; // RL18
  assign tmo     = osc_rise & (cnt_q >= limit - CNT_W'(1)) & (mode != MODE_STOP);
  assign irq_set  = tmo & ((mode == MODE_IRQ) | ((mode == MODE_BOTH) & ~timeout_flag_q));
  assign rst_fire = tmo & ((mode == MODE_RST) | ((mode == MODE_BOTH) & timeout_flag_q)); // RL14

  // Counter runs on oscillator edges; restart, stop or a time-out clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (restart_exec || mode == MODE_STOP || tmo) begin
      cnt_q <= '0; // RL22
    end else if (osc_rise) begin
      cnt_q <= cnt_q + CNT_W'(1); // RL20
    end
  end

  // One-cycle system reset pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_pulse <= 1'b0;
    end else begin
      sys_reset_pulse <= rst_fire; // RL21
    end
  end

  assign irq_req = global_int_enable & timeout_interrupt_enable_eff & timeout_flag_q; // RL10

  // ==========================================================
  // Reset-cause flags: a set beats a software clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= wdg_cause_t'(CAUSE_RST); // RL6
    end else begin
      cause_q.unused <= 4'h0;
      if (sys_reset_pulse) begin
        cause_q.watchdog_reset_cause_flag <= 1'b1; // RL3
      end else if (wr_cause && !pwdata[3]) begin
        cause_q.watchdog_reset_cause_flag <= 1'b0;
      end
      if (bor_rise) begin
        cause_q.brownout_cause_flag <= 1'b1; // RL4
      end else if (wr_cause && !pwdata[2]) begin
        cause_q.brownout_cause_flag <= 1'b0;
      end
      if (ext_rise) begin
        cause_q.external_pin_cause_flag <= 1'b1; // RL5
      end else if (wr_cause && !pwdata[1]) begin
        cause_q.external_pin_cause_flag <= 1'b0;
      end
      if (wr_cause && !pwdata[0]) begin
        cause_q.power_on_cause_flag <= 1'b0; // RL6
      end
    end
  end

  // ==========================================================
  // Assertions.
  property p_unused_zero;
    (rd_setup && paddr == ADDR_CAUSE) |=> prdata[7:4] == 4'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("cause high bits set"); // RL2
  property p_watchdog_reset_cause_flag_set;
    sys_reset_pulse |=> cause_q.watchdog_reset_cause_flag;
  endproperty
  a_watchdog_reset_cause_flag_set: assert property (p_watchdog_reset_cause_flag_set) else $error("watchdog cause missed"); // RL3
  property p_bor_set;
    bor_rise |=> cause_q.brownout_cause_flag;
  endproperty
  a_bor_set: assert property (p_bor_set) else $error("brown-out cause missed"); // RL4
  property p_ext_set;
    ext_rise |=> cause_q.external_pin_cause_flag;
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("external cause missed"); // RL5
  property p_por_clear;
    $fell(cause_q.power_on_cause_flag) |-> $past(wr_cause && !pwdata[0]);
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("power-on flag lost"); // RL6
  property p_irq_flag;
    (tmo && mode == MODE_IRQ) |=> timeout_flag_q ##1 (timeout_flag_q || $past(vector_exec || wr_ctrl));
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("time-out flag not set"); // RL9
  property p_irq_cause;
    irq_req |-> (timeout_flag_q && timeout_interrupt_enable_q && global_int_enable && !fuse_prog);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("spurious interrupt"); // RL10
  property p_fuse_reset;
    (tmo && fuse_prog) |=> sys_reset_pulse ##1 !sys_reset_pulse;
  endproperty
  a_fuse_reset: assert property (p_fuse_reset) else $error("fuse reset missed"); // RL12 RL21
  property p_vec_both;
    (vector_exec && mode == MODE_BOTH && !tmo && !wr_ctrl) |=> !timeout_interrupt_enable_q && !timeout_flag_q;
  endproperty
  a_vec_both: assert property (p_vec_both) else $error("vector did not disarm"); // RL13
  property p_second_tmo;
    (tmo && mode == MODE_BOTH && timeout_flag_q) |=> sys_reset_pulse;
  endproperty
  a_second_tmo: assert property (p_second_tmo) else $error("second time-out no reset"); // RL14
  property p_ce_window;
    (wr_ctrl && w.change_enable && w.system_reset_enable) ##1 (!wr_ctrl)[*4]
      |=> !ce_active;
  endproperty
  a_ce_window: assert property (p_ce_window) else $error("change enable stuck"); // RL16
  property p_wde_hold;
    (cause_q.watchdog_reset_cause_flag && wde_q) |=> wde_q;
  endproperty
  a_wde_hold: assert property (p_wde_hold) else $error("reset enable dropped"); // RL17
  property p_restart;
    restart_exec |=> cnt_q == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart ignored"); // RL22
  c_irq_mode: cover property (@(posedge pclk) disable iff (!presetn) irq_set && mode == MODE_IRQ);
  c_both_rst: cover property (@(posedge pclk) disable iff (!presetn) rst_fire && mode == MODE_BOTH);
  c_unlock: cover property (@(posedge pclk) disable iff (!presetn) cfg_write && !w.system_reset_enable);

endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps

// ==========================================================
// Self-checking bench for the watchdog block.
module testbench import wdg_pkg::*;;
  localparam int unsigned TB = 4;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, serr, osc_clk_in, always_on_fuse, global_int_enable;
  logic        vector_exec, restart_exec, brownout_reset, external_reset;
  logic        irq_req, sys_reset_pulse;
  int          failures, checks_done, cycles, osc_cnt, base;
  logic [3:0]  codes [4] = '{4'h0, 4'h1, 4'h3, 4'ha};

  wdg_top #(.TIMEOUT_BASE(TB)) wdg_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_clk_in(osc_clk_in), .always_on_fuse(always_on_fuse),
    .global_int_enable(global_int_enable), .vector_exec(vector_exec),
    .restart_exec(restart_exec), .brownout_reset(brownout_reset),
    .external_reset(external_reset), .irq_req(irq_req), .sys_reset_pulse(sys_reset_pulse));

  // ==========================================================
  // Core clock at 250 MHz and a slower, unrelated oscillator.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    osc_clk_in = 1'b0;
    #7;
    forever #20 osc_clk_in = ~osc_clk_in;
  end
  always @(posedge osc_clk_in) osc_cnt <= osc_cnt + 1;

  // Cuts a hung run short.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      $display("[ERR] %0t run timed out", $time);
      final_report();
    end
  end

  // ==========================================================
  // Comparison, bus and event tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Access phase held until pready is sampled high; only the bench timeout ends a wait.
  task automatic xfer();
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= a;
    pwdata <= {24'h000000, d};
    xfer();
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= 1'b0;
    paddr <= a;
    xfer();
    chk(rdat, {24'h000000, exp});
  endtask

  // One-cycle pulse: 0 restart, 1 vector.
  task automatic pulse(input int w);
    @(posedge pclk);
    if (w == 0) restart_exec <= 1'b1;
    else vector_exec <= 1'b1;
    @(posedge pclk);
    restart_exec <= 1'b0;
    vector_exec <= 1'b0;
  endtask

  // Restart just after a counted oscillator edge, so edges are counted exactly.
  task automatic align();
    @(posedge osc_clk_in);
    repeat (5) @(posedge pclk);
    pulse(0);
    base = osc_cnt;
  endtask

  // Waits for 0 interrupt request or 1 reset pulse.
  task automatic wait_ev(input int sel, input int max);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (((sel == 0) ? irq_req : sys_reset_pulse) !== 1'b1 && n < max);
    chk(n < max, 1'b1);
  endtask

  task automatic final_report();
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, vector_exec, restart_exec} = 6'h00;
    {brownout_reset, external_reset, global_int_enable} = 3'h0;
    {paddr, pwdata, always_on_fuse} = {12'h000, 32'h00000000, 1'b1};
    {failures, checks_done, cycles, osc_cnt, base} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(ADDR_CTRL, 8'h00);
    rd(ADDR_CAUSE, 8'h01);
    rd(12'h070, 8'h00);
    chk(serr, 1'b1);
    brownout_reset <= 1'b1;
    repeat (4) @(posedge pclk);
    brownout_reset <= 1'b0;
    rd(ADDR_CAUSE, 8'h05);
    external_reset <= 1'b1;
    repeat (4) @(posedge pclk);
    external_reset <= 1'b0;
    rd(ADDR_CAUSE, 8'h07);
    wr(ADDR_CAUSE, 8'hff);
    rd(ADDR_CAUSE, 8'h07);
    wr(ADDR_CAUSE, 8'hf0);
    rd(ADDR_CAUSE, 8'h00);
    // Interrupt mode: flag, gating and both ways of clearing.
    global_int_enable <= 1'b1;
    wr(ADDR_CTRL, 8'h40);
    align();
    wait_ev(0, 100);
    rd(ADDR_CTRL, 8'hc0);
    global_int_enable <= 1'b0;
    @(negedge pclk);
    chk(irq_req, 1'b0);
    global_int_enable <= 1'b1;
    wr(ADDR_CTRL, 8'hc0);
    rd(ADDR_CTRL, 8'h40);
    wait_ev(0, 100);
    pulse(1);
    rd(ADDR_CTRL, 8'h40);
    // Stopped mode raises nothing.
    wr(ADDR_CTRL, 8'h00);
    pulse(0);
    repeat (120) @(posedge pclk);
    rd(ADDR_CTRL, 8'h00);
    // Change window opens, then expires after four cycles.
    wr(ADDR_CTRL, 8'h18);
    rd(ADDR_CTRL, 8'h18);
    repeat (6) @(posedge pclk);
    wr(ADDR_CTRL, 8'h01);
    rd(ADDR_CTRL, 8'h08);
    // Reset mode time-out lengths, pulse width and cause flag.
    foreach (codes[i]) begin
      pulse(0);
      wr(ADDR_CAUSE, 8'h00);
      wr(ADDR_CTRL, 8'h18);
      wr(ADDR_CTRL, {2'b00, codes[i][3], 2'b01, codes[i][2:0]});
      rd(ADDR_CTRL, {2'b00, codes[i][3], 2'b01, codes[i][2:0]});
      align();
      wait_ev(1, 25000);
      chk(osc_cnt - base, TB << ((codes[i] > 4'h9) ? 9 : codes[i]));
      @(negedge pclk);
      chk(sys_reset_pulse, 1'b0);
      rd(ADDR_CAUSE, 8'h08);
    end
    pulse(0);
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h08);
    wr(ADDR_CAUSE, 8'h00);
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h00);
    // Combined mode: unserviced second time-out resets.
    wr(ADDR_CTRL, 8'h48);
    align();
    wait_ev(0, 100);
    rd(ADDR_CTRL, 8'hc8);
    wait_ev(1, 100);
    pulse(0);
    wr(ADDR_CAUSE, 8'h00);
    wr(ADDR_CTRL, 8'hc8);
    align();
    wait_ev(0, 100);
    pulse(1);
    rd(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h48);
    rd(ADDR_CTRL, 8'h48);
    // Programmed fuse forces reset mode over interrupt mode.
    pulse(0);
    wr(ADDR_CAUSE, 8'h00);
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h40);
    always_on_fuse <= 1'b0;
    align();
    wait_ev(1, 100);
    chk(irq_req, 1'b0);
    final_report();
  end
endmodule
